//--- sim/ccs_partner.sv
// Far-side model: capture input source and group B power stage pins.
// Assumes fire requests arrive just after a rising pclk edge.
`timescale 1ns/100ps
`default_nettype none
module ccs_partner (
    // Clock and request
    input wire logic pclk,
    input wire logic fire,
    input wire logic slow,
    // Pins
    input wire logic [2:0] bdf_o,
    input wire logic [2:0] bdf_oe,
    output logic capture_pin,
    output logic [2:0] bdf_level
);
    // ==========
    // Capture source: short or long high pulse per request
    logic [2:0] cnt_ff = 3'h0;
    logic [2:0] last_ff = 3'h0;
    always @(posedge pclk) begin
        if (fire) begin
            cnt_ff <= slow ? 3'h7 : 3'h2;
        end else if (cnt_ff != 3'h0) begin
            cnt_ff <= cnt_ff - 3'h1;
        end
    end
    assign capture_pin = (cnt_ff != 3'h0);
    // Undriven pins show the inverse of the last driven level
    always @(posedge pclk) last_ff <= (bdf_oe & bdf_o) | (~bdf_oe & last_ff);
    assign bdf_level = (bdf_oe & bdf_o) | (~bdf_oe & ~last_ff);
endmodule
`default_nettype wire

//--- sim/ccs_status_top_tb_top.sv
// Self-checking bench for the status, dead-time and shutdown slice.
// Assumes the APB slave answers in the first access cycle or later.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module ccs_status_top_tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd, v;
    logic pready, pslverr, er, timer_run, capture_event, fire = 1'b0;
    // Timer-side events: hw trigger, shutdown, period start, compare, overflow
    logic [4:0] ev = 5'h00;
    wire logic hw_trigger = ev[0], shutdown_in = ev[1], period_start = ev[2], compare_event = ev[3];
    wire logic capture_overflow = ev[4];
    wire logic [2:0] lvl;
    logic capture_gate = 1'b0, capture_not_empty = 1'b0;
    logic [4:0] upd = 5'h00;
    logic [2:0] pwm_in = 3'h0, ace_o, ace_oe, bdf_o, bdf_oe;
    wire logic capture_pin;
    int fail_count = 0, samples_checked = 0, m_con3, cnt;
    int codes[$] = '{3, 2, 0, 1};
    int dts[$] = '{0, 1, 2, 5, 63};
    // ==========
    // Clock and instances
    always #4 pclk = ~pclk;
    ccs_status_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .update_busy(upd), .hw_trigger(hw_trigger), .shutdown_in(shutdown_in),
        .period_start(period_start), .compare_event(compare_event), .capture_pin(capture_pin),
        .capture_gate(capture_gate), .capture_overflow(capture_overflow),
        .capture_not_empty(capture_not_empty), .pwm_in(pwm_in), .timer_run(timer_run),
        .capture_event(capture_event), .pin_ace_o(ace_o), .pin_ace_oe(ace_oe),
        .pin_bdf_o(bdf_o), .pin_bdf_oe(bdf_oe));
    ccs_partner far (.pclk(pclk), .fire(fire), .slow(v[0]), .bdf_o(bdf_o), .bdf_oe(bdf_oe),
        .capture_pin(capture_pin), .bdf_level(lvl));
    // ==========
    // APB transfer; read data and error land in rd and er
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata; er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    // One-cycle pulse on a timer-side input
    task automatic pulse(input int k);
        ev[k] <= 1'b1;
        @(posedge pclk) ev[k] <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask
    // Fire the capture source and count capture events from the fire edge on
    task cap(input int want);
        v = $urandom;
        cnt = 0;
        fire <= 1'b1;
        repeat (12) @(posedge pclk) begin
            fire <= 1'b0;
            cnt += capture_event;
        end
        `CHK(cnt, want)
    endtask
    task end_of_test;
        $display("mismatches %0d, comparisons %0d", fail_count, samples_checked);
        if (fail_count == 0 && samples_checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ==========
    // Watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        end_of_test;
    end
    // ==========
    // Main sequence
    initial begin
        void'($urandom(32'h1291_8c4e));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 12; a += 4) begin
            apb(1'b0, a[11:0], 32'h0000_0000);
            `CHK(rd, (a == ccs_pkg::CCS_ADDR_STAT) ? 32'h0000_0004 : 32'h0000_0000)
        end
        apb(1'b0, 12'h00c, 32'h0000_0000);
        `CHK({er, rd}, {1'b1, 32'h0000_0000})
        // Control 3 write and read back, unimplemented bits zero
        repeat (4) begin
            m_con3 = $urandom & ccs_pkg::CCS_CON3_MASK;
            apb(1'b1, ccs_pkg::CCS_ADDR_CON3, ($urandom & ~ccs_pkg::CCS_CON3_MASK) | m_con3);
            apb(1'b0, ccs_pkg::CCS_ADDR_CON3, 32'h0000_0000);
            `CHK(rd, m_con3)
        end
        apb(1'b1, ccs_pkg::CCS_ADDR_CON3, 32'h0000_0000);
        // Update pending flags follow the transfers, last pass all idle
        for (int i = 0; i < 5; i++) begin
            upd <= (i == 4) ? 5'h00 : 5'($urandom);
            repeat (3) @(posedge pclk);
            apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
            `CHK(rd[20:16], upd)
        end
        // Trigger set, clear and hardware trigger
        apb(1'b1, ccs_pkg::CCS_ADDR_CTRL, 32'h0000_0001);
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0440);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK({rd[10], rd[7:5], timer_run}, 5'b01001)
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0020);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK(rd[7:5], 3'b000)
        pulse(0); // hw trigger
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK(rd[7], 1'b1)
        // Sticky flags hold until written with zero
        pulse(3); // compare event
        pulse(4); // capture overflow
        capture_not_empty <= 1'b1;
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_001a);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK({rd[3], rd[1:0]}, 3'b111)
        capture_not_empty <= 1'b0;
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK({rd[3], rd[1:0]}, 3'b000)
        // Group B shutdown state for every code, software clear
        foreach (codes[i]) begin
            apb(1'b1, ccs_pkg::CCS_ADDR_CON3, codes[i] << 16);
            ev[1] <= 1'b1;
            repeat (3) @(posedge pclk);
            `CHK({ace_oe, bdf_oe}, {3'b000, {3{codes[i][1]}}})
            if (codes[i][1]) `CHK({bdf_o, lvl}, {2{{3{codes[i][0]}}}})
            apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
            `CHK(rd[4], 1'b1)
            ev[1] <= 1'b0;
            apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
            apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
            `CHK({rd[4], ace_oe}, 4'b0111)
        end
        // Restart enable clears the shutdown flag at the next period
        apb(1'b1, ccs_pkg::CCS_ADDR_CTRL, 32'h0000_0003);
        pulse(1); // shutdown input
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK(rd[4], 1'b1)
        pulse(2); // period start
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK(rd[4], 1'b0)
        // Dead time: count cycles with both sides low after a rise
        foreach (dts[i]) begin
            apb(1'b1, ccs_pkg::CCS_ADDR_CON3, dts[i]);
            pwm_in <= 3'h0;
            repeat (70) @(posedge pclk);
            pwm_in <= 3'h7;
            cnt = 0;
            repeat (dts[i] + 4) @(posedge pclk) cnt += (ace_o[0] === 1'b0 && bdf_o[0] === 1'b0);
            `CHK({cnt, ace_o[0]}, {dts[i], 1'b1})
        end
        // Level gating, then one-shot modes with arm
        cap(0);
        capture_gate <= 1'b1;
        cap(1);
        apb(1'b1, ccs_pkg::CCS_ADDR_CTRL, 32'h0000_0008);
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0400);
        capture_gate <= 1'b0;
        repeat (2) @(posedge pclk);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK({rd[10], rd[2]}, 2'b01)
        cap(0);
        apb(1'b1, ccs_pkg::CCS_ADDR_CTRL, 32'h0000_0004);
        apb(1'b1, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0404);
        capture_gate <= 1'b1;
        repeat (2) @(posedge pclk);
        apb(1'b0, ccs_pkg::CCS_ADDR_STAT, 32'h0000_0000);
        `CHK(rd[2], 1'b0)
        cap(1);
        end_of_test;
    end
endmodule
`default_nettype wire

//--- src/ccs_deadtime.sv
// One complementary pair with dead-time insertion.
// Assumes pwm_in synchronous to pclk; dead_time_count static while running.
`timescale 1ns/100ps
`default_nettype none
module ccs_deadtime (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic [5:0] dead_time_count,
    input wire logic pwm_in,
    // Outputs
    output logic out_hi_ff,
    output logic out_lo_ff
);
    ccs_pkg::ccs_dt_state_t st_ff, nxt_st;
    logic [5:0] cnt_ff, nxt_cnt;
    logic nxt_hi, nxt_lo;

    // Next state: on each edge of pwm_in both sides go low for n cycles
    always_comb begin
        nxt_st = st_ff;
        nxt_cnt = cnt_ff;
        nxt_hi = out_hi_ff;
        nxt_lo = out_lo_ff;
        if (dead_time_count == ccs_pkg::CCS_DT_OFF) begin
            nxt_st = ccs_pkg::CCS_DT_IDLE;
            nxt_hi = pwm_in;
            nxt_lo = !pwm_in;
        end else begin
            case (st_ff)
                ccs_pkg::CCS_DT_IDLE: begin
                    if (pwm_in != out_hi_ff || pwm_in == out_lo_ff) begin
                        nxt_hi = 1'b0;
                        nxt_lo = 1'b0;
                        nxt_cnt = dead_time_count - 6'h01;
                        nxt_st = ccs_pkg::CCS_DT_WAIT;
                    end
                end
                ccs_pkg::CCS_DT_WAIT: begin
                    if (cnt_ff == 6'h00) begin
                        nxt_hi = pwm_in;
                        nxt_lo = !pwm_in;
                        nxt_st = ccs_pkg::CCS_DT_IDLE;
                    end else begin
                        nxt_cnt = cnt_ff - 6'h01;
                    end
                end
                default: nxt_st = ccs_pkg::CCS_DT_IDLE;
            endcase
        end
    end

    // Register the pair
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= ccs_pkg::CCS_DT_IDLE;
            cnt_ff <= 6'h00;
            out_hi_ff <= 1'b0;
            out_lo_ff <= 1'b0;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= nxt_cnt;
            out_hi_ff <= nxt_hi;
            out_lo_ff <= nxt_lo;
        end
    end

    // Assertions
    a_dt_zero_direct: assert property (@(posedge pclk) disable iff (!presetn)
        (dead_time_count == 6'h00 && $stable(dead_time_count)) |=> (out_hi_ff == $past(pwm_in)))
        else $error("zero dead time did not pass pwm through");
    a_dt_no_overlap: assert property (@(posedge pclk) disable iff (!presetn)
        !(out_hi_ff && out_lo_ff))
        else $error("both complementary outputs high");
    a_dt_gap_len: assert property (@(posedge pclk) disable iff (!presetn)
        (st_ff == ccs_pkg::CCS_DT_IDLE && dead_time_count == 6'h02 && $stable(dead_time_count)
         && pwm_in != out_hi_ff) |=> (!out_hi_ff && !out_lo_ff)[*2])
        else $error("dead time gap shorter than programmed");
    c_dt_gap: cover property (@(posedge pclk) disable iff (!presetn) st_ff == ccs_pkg::CCS_DT_WAIT);
endmodule
`default_nettype wire

//--- src/ccs_pkg.sv
// Constants, register map and types for the capture/compare status,
// dead-time and shutdown slice.
// Assumes a single 125 MHz clock and an APB register bus.
//
// How it works
// - Group B shutdown state: 11 drives active, 10 inactive, 0x floats.
// - Nonzero dead-time value n inserts exactly n delay periods.
// - Dead-time zero disables insertion; complementary outputs switch at once.
// - Group B shutdown and dead-time fields exist only in the multi-output variant.
// - Unimplemented register bits read as zero.
// - Period update pending reads 1 during period transfer.
// - Timer high and low pending flags read 1 during their transfers.
// - Compare A and B pending flags read 1 during their updates.
// - Writing gate arm arms one-shot gating in modes 01 or 10; reads zero.
// - Trigger status is 1 when triggered and running, 0 after clear.
// - Trigger set write triggers timer when triggered operation enabled; reads zero.
// - Trigger clear write cancels trigger when triggered operation enabled; reads zero.
// - Shutdown flag is 1 during shutdown, 0 normally, software clearable.
// - Compare event flag sets on event, stays until software clears.
// - Capture disable blocks capture events from the capture input.
// - Capture overflow flag sets on FIFO overflow, stays until cleared.
// - Capture not empty flag follows capture buffer contents.
// - With restart enable, shutdown flag clears at next period after input ends.
// - Gating mode 10 falling sets disable, 01 rising clears, 00 level.
package ccs_pkg;

    // ==================================================
    // Register byte addresses
    localparam logic [11:0] CCS_ADDR_CON3 = 12'h000;
    localparam logic [11:0] CCS_ADDR_STAT = 12'h004;
    localparam logic [11:0] CCS_ADDR_CTRL = 12'h008;

    // ==================================================
    // Control 3 fields
    localparam int CCS_DT_LSB = 0;
    localparam int CCS_DT_W = 6;
    localparam int CCS_PSSB_LSB = 16;
    localparam logic [31:0] CCS_CON3_MASK = 32'h0003_003f;
    localparam logic [5:0] CCS_DT_OFF = 6'h00;

    // ==================================================
    // Status bits
    localparam int CCS_B_NE = 0;
    localparam int CCS_B_OV = 1;
    localparam int CCS_B_DIS = 2;
    localparam int CCS_B_CMP = 3;
    localparam int CCS_B_SD = 4;
    localparam int CCS_B_TCLR = 5;
    localparam int CCS_B_TSET = 6;
    localparam int CCS_B_TRIG = 7;
    localparam int CCS_B_ARM = 10;
    localparam int CCS_B_WIP = 16;
    localparam int CCS_WIP_W = 5;

    // ==================================================
    // Extra control register fields
    localparam int CCS_C_TRIGGERED_OPERATION_ENABLE = 0;
    localparam int CCS_C_RSEN = 1;
    localparam int CCS_C_GSM = 2;
    localparam logic [31:0] CCS_CTRL_MASK = 32'h0000_000f;

    // ==================================================
    // Shutdown state and gating mode codes
    localparam logic [1:0] CCS_SD_ACTIVE = 2'h3;
    localparam logic [1:0] CCS_SD_INACTIVE = 2'h2;
    localparam logic [1:0] CCS_GSM_LEVEL = 2'h0;
    localparam logic [1:0] CCS_GSM_RISE = 2'h1;
    localparam logic [1:0] CCS_GSM_FALL = 2'h2;

    // Number of complementary pairs
    localparam int CCS_PAIRS = 3;

    // Dead-time output state
    typedef enum logic [1:0] {CCS_DT_IDLE, CCS_DT_WAIT} ccs_dt_state_t;

endpackage

//--- src/ccs_status_top.sv
// Status, dead-time and group B shutdown slice of a capture/compare timer.
// Assumes APB master on pclk; all event inputs are one-cycle pulses or levels
// synchronous to pclk from the rest of the timer.
//
// The register offsets and the APB interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module ccs_status_top (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer side events and levels
    input wire logic [4:0] update_busy,
    input wire logic hw_trigger,
    input wire logic shutdown_in,
    input wire logic period_start,
    input wire logic compare_event,
    input wire logic capture_pin,
    input wire logic capture_gate,
    input wire logic capture_overflow,
    input wire logic capture_not_empty,
    input wire logic [2:0] pwm_in,
    // Timer side controls
    output logic timer_run,
    output logic capture_event,
    // Group A/C/E pins
    output logic [2:0] pin_ace_o,
    output logic [2:0] pin_ace_oe,
    // Group B/D/F pins
    output logic [2:0] pin_bdf_o,
    output logic [2:0] pin_bdf_oe
);
    // Multi-output variant fields are present
    localparam bit MULTI_OUTPUT = 1'b1;

    // ==================================================
    // Bus decode
    logic wr_en, rd_en, hit_con3, hit_stat, hit_ctrl;
    logic [31:0] con3_ff, nxt_con3;
    logic [31:0] ctrl_ff, nxt_ctrl;
    logic [31:0] prdata_ff, nxt_prdata;
    logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;

    // Address match helper
    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] r);
        addr_is = (a == r);
    endfunction

    // Decode and strobes
    always_comb begin
        hit_con3 = addr_is(paddr, ccs_pkg::CCS_ADDR_CON3);
        hit_stat = addr_is(paddr, ccs_pkg::CCS_ADDR_STAT);
        hit_ctrl = addr_is(paddr, ccs_pkg::CCS_ADDR_CTRL);
        wr_en = psel && penable && pready_ff && pwrite;
        rd_en = psel && !penable && !pwrite;
    end

    // ==================================================
    // Status state
    logic trig_ff, nxt_trig;
    logic sd_ff, nxt_sd;
    logic cmp_ff, nxt_cmp;
    logic dis_ff, nxt_dis;
    logic ov_ff, nxt_ov;
    logic armed_ff, nxt_armed;
    logic gate_d_ff, nxt_gate_d;
    logic cap_d_ff, nxt_cap_d;
    logic cap_ev_ff, nxt_cap_ev;
    logic [4:0] wip_ff, nxt_wip;
    logic [31:0] stat_rd;
    logic [1:0] gsm;
    logic triggered_operation_enable, rsen;

    // Status readback; write-only and unimplemented bits read zero
    always_comb begin
        stat_rd = 32'h0000_0000;
        stat_rd[ccs_pkg::CCS_B_WIP +: ccs_pkg::CCS_WIP_W] = wip_ff;
        stat_rd[ccs_pkg::CCS_B_TRIG] = trig_ff;
        stat_rd[ccs_pkg::CCS_B_SD] = sd_ff;
        stat_rd[ccs_pkg::CCS_B_CMP] = cmp_ff;
        stat_rd[ccs_pkg::CCS_B_DIS] = dis_ff;
        stat_rd[ccs_pkg::CCS_B_OV] = ov_ff;
        stat_rd[ccs_pkg::CCS_B_NE] = capture_not_empty;
        gsm = ctrl_ff[ccs_pkg::CCS_C_GSM +: 2];
        triggered_operation_enable = ctrl_ff[ccs_pkg::CCS_C_TRIGGERED_OPERATION_ENABLE];
        rsen = ctrl_ff[ccs_pkg::CCS_C_RSEN];
    end

    // Register writes and APB answer (no wait state: pready in first access cycle)
    always_comb begin
        nxt_con3 = con3_ff;
        nxt_ctrl = ctrl_ff;
        nxt_prdata = prdata_ff;
        nxt_pready = psel && !penable;
        nxt_pslverr = 1'b0;
        if (psel && !penable) begin
            nxt_pslverr = !(hit_con3 || hit_stat || hit_ctrl);
            if (rd_en) begin
                if (hit_con3) begin
                    nxt_prdata = con3_ff;
                end else if (hit_stat) begin
                    nxt_prdata = stat_rd;
                end else if (hit_ctrl) begin
                    nxt_prdata = ctrl_ff;
                end else begin
                    nxt_prdata = 32'h0000_0000;
                end
            end
        end
        if (wr_en && hit_con3) begin
            nxt_con3 = MULTI_OUTPUT ? (pwdata & ccs_pkg::CCS_CON3_MASK) : 32'h0000_0000;
        end else if (wr_en && hit_ctrl) begin
            nxt_ctrl = pwdata & ccs_pkg::CCS_CTRL_MASK;
        end
    end

    // Status flags; hardware set wins over software clear
    always_comb begin
        logic stw;
        logic gate_rise, gate_fall;
        stw = wr_en && hit_stat;
        gate_rise = capture_gate && !gate_d_ff;
        gate_fall = !capture_gate && gate_d_ff;
        nxt_wip = update_busy;
        nxt_gate_d = capture_gate;
        nxt_cap_d = capture_pin;
        // Trigger
        nxt_trig = trig_ff;
        if (hw_trigger) begin
            nxt_trig = 1'b1;
        end else if (stw && triggered_operation_enable && pwdata[ccs_pkg::CCS_B_TSET]) begin
            nxt_trig = 1'b1;
        end else if (stw && triggered_operation_enable && pwdata[ccs_pkg::CCS_B_TCLR]) begin
            nxt_trig = 1'b0;
        end
        // Shutdown flag
        nxt_sd = sd_ff;
        if (shutdown_in) begin
            nxt_sd = 1'b1;
        end else if (stw && !pwdata[ccs_pkg::CCS_B_SD]) begin
            nxt_sd = 1'b0;
        end else if (rsen && sd_ff && period_start) begin
            nxt_sd = 1'b0;
        end
        // Compare event
        nxt_cmp = cmp_ff;
        if (compare_event) begin
            nxt_cmp = 1'b1;
        end else if (stw && !pwdata[ccs_pkg::CCS_B_CMP]) begin
            nxt_cmp = 1'b0;
        end
        // Overflow
        nxt_ov = ov_ff;
        if (capture_overflow) begin
            nxt_ov = 1'b1;
        end else if (stw && !pwdata[ccs_pkg::CCS_B_OV]) begin
            nxt_ov = 1'b0;
        end
        // Gate arm and capture disable
        nxt_armed = armed_ff;
        nxt_dis = dis_ff;
        if (stw && pwdata[ccs_pkg::CCS_B_ARM] && (gsm == ccs_pkg::CCS_GSM_RISE || gsm == ccs_pkg::CCS_GSM_FALL)) begin
            nxt_armed = 1'b1;
        end
        if (gsm == ccs_pkg::CCS_GSM_LEVEL) begin
            nxt_dis = !capture_gate;
            nxt_armed = 1'b0;
        end else if (armed_ff && gsm == ccs_pkg::CCS_GSM_FALL && gate_fall) begin
            nxt_dis = 1'b1;
            nxt_armed = 1'b0;
        end else if (armed_ff && gsm == ccs_pkg::CCS_GSM_RISE && gate_rise) begin
            nxt_dis = 1'b0;
            nxt_armed = 1'b0;
        end else if (stw && !pwdata[ccs_pkg::CCS_B_DIS]) begin
            nxt_dis = 1'b0;
        end
        // Capture input edge gated by disable
        nxt_cap_ev = (capture_pin && !cap_d_ff) && !dis_ff;
    end

    // Register all control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con3_ff <= 32'h0000_0000;
            ctrl_ff <= 32'h0000_0000;
            prdata_ff <= 32'h0000_0000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            trig_ff <= 1'b0;
            sd_ff <= 1'b0;
            cmp_ff <= 1'b0;
            dis_ff <= 1'b0;
            ov_ff <= 1'b0;
            armed_ff <= 1'b0;
            gate_d_ff <= 1'b0;
            cap_d_ff <= 1'b0;
            cap_ev_ff <= 1'b0;
            wip_ff <= 5'h00;
        end else begin
            con3_ff <= nxt_con3;
            ctrl_ff <= nxt_ctrl;
            prdata_ff <= nxt_prdata;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            trig_ff <= nxt_trig;
            sd_ff <= nxt_sd;
            cmp_ff <= nxt_cmp;
            dis_ff <= nxt_dis;
            ov_ff <= nxt_ov;
            armed_ff <= nxt_armed;
            gate_d_ff <= nxt_gate_d;
            cap_d_ff <= nxt_cap_d;
            cap_ev_ff <= nxt_cap_ev;
            wip_ff <= nxt_wip;
        end
    end

    // ==================================================
    // Dead time and pin drive
    logic [2:0] dt_hi, dt_lo;
    logic [2:0] nxt_ace_o, nxt_ace_oe, nxt_bdf_o, nxt_bdf_oe;
    logic [2:0] ace_o_ff, ace_oe_ff, bdf_o_ff, bdf_oe_ff;
    logic run_ff;
    logic [1:0] pssb;

    // One dead-time pair per output pair
    genvar gi;
    generate
        for (gi = 0; gi < ccs_pkg::CCS_PAIRS; gi++) begin : g_pair
            ccs_deadtime u_dt (
                .pclk(pclk),
                .presetn(presetn),
                .dead_time_count(con3_ff[ccs_pkg::CCS_DT_LSB +: ccs_pkg::CCS_DT_W]),
                .pwm_in(pwm_in[gi]),
                .out_hi_ff(dt_hi[gi]),
                .out_lo_ff(dt_lo[gi])
            );
        end
    endgenerate

    // Group B shutdown state selection
    always_comb begin
        pssb = con3_ff[ccs_pkg::CCS_PSSB_LSB +: 2];
        nxt_ace_o = dt_hi;
        nxt_ace_oe = 3'h7;
        nxt_bdf_o = dt_lo;
        nxt_bdf_oe = 3'h7;
        if (sd_ff) begin
            nxt_ace_o = 3'h0;
            nxt_ace_oe = 3'h0;
            if (pssb == ccs_pkg::CCS_SD_ACTIVE) begin
                nxt_bdf_o = 3'h7;
            end else if (pssb == ccs_pkg::CCS_SD_INACTIVE) begin
                nxt_bdf_o = 3'h0;
            end else begin
                nxt_bdf_o = 3'h0;
                nxt_bdf_oe = 3'h0;
            end
        end
    end

    // Output pin registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ace_o_ff <= 3'h0;
            ace_oe_ff <= 3'h0;
            bdf_o_ff <= 3'h0;
            bdf_oe_ff <= 3'h0;
            run_ff <= 1'b0;
        end else begin
            ace_o_ff <= nxt_ace_o;
            ace_oe_ff <= nxt_ace_oe;
            bdf_o_ff <= nxt_bdf_o;
            bdf_oe_ff <= nxt_bdf_oe;
            run_ff <= nxt_trig;
        end
    end

    // Output connections
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign timer_run = run_ff;
    assign capture_event = cap_ev_ff;
    assign pin_ace_o = ace_o_ff;
    assign pin_ace_oe = ace_oe_ff;
    assign pin_bdf_o = bdf_o_ff;
    assign pin_bdf_oe = bdf_oe_ff;

    // ==================================================
    // Assertions
    a_sd_float: assert property (@(posedge pclk) disable iff (!presetn)
        (sd_ff && !pssb[1]) |=> (pin_bdf_oe == 3'h0))
        else $error("group b not floated in shutdown");
    a_sd_active: assert property (@(posedge pclk) disable iff (!presetn)
        (sd_ff && pssb == 2'h3) |=> (pin_bdf_o == 3'h7 && pin_bdf_oe == 3'h7))
        else $error("group b not driven active in shutdown");
    a_stat_zero_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (stat_rd & 32'hffe0_ff60) == 32'h0000_0000)
        else $error("unimplemented status bits not zero");
    a_wip_track: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 (stat_rd[20:16] == $past(update_busy)))
        else $error("pending flags do not follow transfers");
    a_trig_set: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_stat && triggered_operation_enable && pwdata[6]) |=> trig_ff)
        else $error("trigger set request ignored");
    a_trig_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && hit_stat && triggered_operation_enable && pwdata[5] && !pwdata[6] && !hw_trigger) |=> !trig_ff)
        else $error("trigger clear request ignored");
    a_cmp_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        compare_event |=> cmp_ff)
        else $error("compare event flag not set");
    a_ov_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (ov_ff && !(wr_en && hit_stat)) |=> ov_ff)
        else $error("overflow flag lost without clear");
    a_cap_block: assert property (@(posedge pclk) disable iff (!presetn)
        dis_ff |=> !capture_event)
        else $error("capture while disabled");
    a_sd_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (rsen && sd_ff && period_start && !shutdown_in && !(wr_en && hit_stat)) |=> !sd_ff)
        else $error("shutdown flag not auto cleared");
    a_gate_fall: assert property (@(posedge pclk) disable iff (!presetn)
        (armed_ff && gsm == 2'h2 && gate_d_ff && !capture_gate) |=> dis_ff ##1 !armed_ff[*1])
        else $error("armed falling gate did not disable capture");
    a_sd_set: assert property (@(posedge pclk) disable iff (!presetn)
        shutdown_in |=> sd_ff)
        else $error("shutdown flag not set by shutdown input");
    a_hw_trig: assert property (@(posedge pclk) disable iff (!presetn)
        hw_trigger |=> trig_ff)
        else $error("hardware trigger ignored");
    c_shutdown: cover property (@(posedge pclk) disable iff (!presetn) shutdown_in ##1 sd_ff);
    c_trigger: cover property (@(posedge pclk) disable iff (!presetn) !trig_ff ##1 trig_ff);
    c_capture: cover property (@(posedge pclk) disable iff (!presetn) capture_event);
    c_arm: cover property (@(posedge pclk) disable iff (!presetn) !armed_ff ##1 armed_ff);
endmodule
`default_nettype wire
